/* File: rtl/pcra_agent.sv */
// Contract
// - address on AD with frame, then data
// - configuration select taken from AD28
// - command with frame, then byte enables
// - frame marks address; drop means last transfer
// - initiator ready only when able to transfer
// - target stop ends the master's transaction
// - claim positive or subtractive, sample device select
// - one even parity bit over AD and CBE
// - sampled system error raises NMI when enabled
// - channel check also raises NMI
// - hold clock run low while clock runs
// - network uses high priority request pair
// - normal priority pair for other accesses
// - extra low pairs only when config bit 2
`timescale 1ns/1ps
module pcra_agent import pcra_pkg::*; (
	input wire logic clk, // bus clock
	input wire logic rst_n, // bus reset, active low
	input wire logic [31:0] ad_in, // address/data as seen on the bus
	output logic [31:0] ad_out, // address/data driven
	output logic ad_oe, // address/data enable
	input wire logic [3:0] cbe_n_in, // command/byte enables seen
	output logic [3:0] cbe_n_out, // command/byte enables driven
	output logic cbe_oe, // command/byte enable drive enable
	input wire logic frame_n_in, // frame seen
	output logic frame_n_out, // frame driven
	output logic frame_oe, // frame drive enable
	input wire logic irdy_n_in, // initiator ready seen
	output logic irdy_n_out, // initiator ready driven
	output logic irdy_oe, // initiator ready drive enable
	input wire logic trdy_n_in, // target ready seen
	input wire logic stop_n_in, // target stop seen
	input wire logic devsel_n_in, // device select seen
	output logic devsel_n_out, // device select driven
	output logic devsel_oe, // device select drive enable
	input wire logic par_in, // parity seen
	output logic par_out, // parity driven
	output logic par_oe, // parity drive enable
	output logic parity_error, // one-cycle pulse on bad parity
	input wire logic serr_n, // system error, active low
	input wire logic chan_check_n, // isa channel check, active low
	input wire logic nmi_on_serr, // enable nmi from system error
	output logic nmi, // non-maskable interrupt to cpu
	input wire logic bus_clock_run_n_in, // clock run seen
	output logic bus_clock_run_n_out, // clock run driven low
	output logic bus_clock_run_oe, // clock run drive enable
	input wire logic clk_stop_req, // power logic wants bus clock off
	output logic clk_stop_ok, // bus clock may be stopped
	output logic hi_prio_bus_request_n, // high priority request
	input wire logic hi_prio_bus_grant_n, // high priority grant
	output logic norm_prio_bus_request_n, // normal priority request
	input wire logic norm_prio_bus_grant_n, // normal priority grant
	input wire logic mst_start, // pulse: begin a single transfer
	input wire logic mst_hi_prio, // transfer is for the network controller
	input wire logic [3:0] mst_cmd, // bus command
	input wire logic [31:0] mst_addr, // address
	input wire logic [31:0] mst_wdata, // write data
	input wire logic [3:0] mst_be_n, // byte enables
	output logic mst_busy, // transfer in progress
	output logic mst_done, // pulse: transfer ended
	output logic mst_abort, // pulse: ended without claim or by stop
	output logic [31:0] mst_rdata, // read data
	input wire logic positive_hit, // address decodes to this device
	input wire logic subtractive_en, // claim unclaimed cycles
	output logic tgt_cfg_hit, // pulse: configuration cycle for us
	input wire logic [7:0] arbiter_pin_config, // arbiter pin configuration
	input wire logic ext_hi_request_1_n, // extra high request 1
	input wire logic ext_hi_request_2_n, // extra high request 2
	input wire logic ext_lo_request_1_n, // extra low request 1
	input wire logic ext_lo_request_2_n, // extra low request 2
	output logic ext_hi_grant_1_n, // extra high grant 1
	output logic ext_hi_grant_2_n, // extra high grant 2
	output logic ext_lo_grant_1_n, // extra low grant 1
	output logic ext_lo_grant_2_n, // extra low grant 2
	input wire logic [3:0] gpo_value, // outputs when pins are plain i/o
	output logic [3:0] gpi_value // inputs when pins are plain i/o
);
	// even parity over 36 bits
	function automatic logic pcra_parity(input logic [31:0] a, input logic [3:0] c);
		pcra_parity = ^{a, c};
	endfunction : pcra_parity

	pcra_mst_t mst_state, next_mst_state;
	pcra_tgt_t tgt_state, next_tgt_state;
	logic [2:0] wait_cnt, next_wait_cnt;
	logic [2:0] tgt_cnt, next_tgt_cnt;
	logic cur_hi, next_cur_hi;
	logic is_write, next_is_write;
	logic [31:0] addr_q, next_addr_q, wdata_q, next_wdata_q;
	logic [3:0] cmd_q, next_cmd_q, be_q, next_be_q;
	logic [31:0] next_ad_out, next_mst_rdata;
	logic next_ad_oe, next_cbe_oe, next_frame_n_out, next_frame_oe;
	logic next_irdy_n_out, next_irdy_oe;
	logic [3:0] next_cbe_n_out;
	logic next_devsel_n_out, next_devsel_oe, next_mst_done, next_mst_abort;
	logic next_hi_req_n, next_norm_req_n, next_tgt_cfg_hit;
	logic bus_idle, granted, par_pend, next_par_pend, next_par_oe, next_par_out;
	logic [35:0] par_src, next_par_src;
	logic next_parity_error, next_nmi;
	logic next_clk_run_oe, next_clk_stop_ok;
	logic [3:0] next_ext_grants, next_gpi;
	logic [1:0] rr, next_rr;

	assign bus_idle = frame_n_in & irdy_n_in;
	assign granted = cur_hi ? ~hi_prio_bus_grant_n : ~norm_prio_bus_grant_n;

	// initiator sequencing: request, address, one data phase, turnaround
	always_comb begin
		next_mst_state = mst_state;
		next_wait_cnt = wait_cnt;
		next_cur_hi = cur_hi;
		next_is_write = is_write;
		next_addr_q = addr_q;
		next_wdata_q = wdata_q;
		next_cmd_q = cmd_q;
		next_be_q = be_q;
		next_ad_out = ad_out;
		next_ad_oe = 1'b0;
		next_cbe_n_out = cbe_n_out;
		next_cbe_oe = 1'b0;
		next_frame_n_out = 1'b1;
		next_frame_oe = 1'b0;
		next_irdy_n_out = 1'b1;
		next_irdy_oe = 1'b0;
		next_mst_done = 1'b0;
		next_mst_abort = 1'b0;
		next_mst_rdata = mst_rdata;
		next_hi_req_n = 1'b1;
		next_norm_req_n = 1'b1;
		case (mst_state)
			PCRA_IDLE: begin
				if (mst_start) begin
					next_cur_hi = mst_hi_prio;
					next_cmd_q = mst_cmd;
					next_addr_q = mst_addr;
					next_wdata_q = mst_wdata;
					next_be_q = mst_be_n;
					next_is_write = mst_cmd[0];
					next_mst_state = PCRA_REQ;
				end
			end
			PCRA_REQ: begin
				// request stays until ownership is taken
				next_hi_req_n = ~cur_hi;
				next_norm_req_n = cur_hi;
				if (granted && bus_idle) begin
					next_ad_out = addr_q;
					next_ad_oe = 1'b1;
					next_cbe_n_out = cmd_q;
					next_cbe_oe = 1'b1;
					next_frame_n_out = 1'b0;
					next_frame_oe = 1'b1;
					next_mst_state = PCRA_ADDR;
				end
			end
			PCRA_ADDR: begin
				// single transfer: frame drops with irdy up, last phase
				next_frame_n_out = 1'b1;
				next_frame_oe = 1'b1;
				next_irdy_n_out = 1'b0;
				next_irdy_oe = 1'b1;
				next_cbe_n_out = be_q;
				next_cbe_oe = 1'b1;
				next_ad_out = wdata_q;
				next_ad_oe = is_write;
				next_wait_cnt = 3'h0;
				next_mst_state = PCRA_DATA;
			end
			PCRA_DATA: begin
				next_frame_oe = 1'b1;
				next_irdy_n_out = 1'b0;
				next_irdy_oe = 1'b1;
				next_cbe_oe = 1'b1;
				next_ad_oe = is_write;
				next_wait_cnt = wait_cnt + 3'h1;
				if (!trdy_n_in && !devsel_n_in) begin
					next_mst_rdata = ad_in;
					next_mst_done = 1'b1;
					next_irdy_n_out = 1'b1;
					next_mst_state = PCRA_TURN;
				end else if (!stop_n_in || (devsel_n_in && wait_cnt == MASTER_ABORT_WAIT)) begin
					next_mst_done = 1'b1;
					next_mst_abort = 1'b1;
					next_irdy_n_out = 1'b1;
					next_mst_state = PCRA_TURN;
				end
			end
			PCRA_TURN: begin
				// drive high for one cycle before releasing
				next_mst_state = PCRA_IDLE;
			end
			default: next_mst_state = PCRA_IDLE;
		endcase
	end

	// target claiming: positive hit early, subtractive after the wait
	always_comb begin
		next_tgt_state = tgt_state;
		next_tgt_cnt = tgt_cnt;
		next_devsel_n_out = 1'b1;
		next_devsel_oe = 1'b0;
		next_tgt_cfg_hit = 1'b0;
		case (tgt_state)
			PCRA_T_IDLE: begin
				if (!frame_n_in && frame_n_out && mst_state != PCRA_ADDR) begin
					next_tgt_cnt = 3'h0;
					next_tgt_state = PCRA_T_DECODE;
					if ((cbe_n_in == CMD_CFG_READ || cbe_n_in == CMD_CFG_WRITE)
						&& ad_in[IDSEL_BIT]) begin
						next_tgt_cfg_hit = 1'b1;
						next_tgt_state = PCRA_T_CLAIM;
					end
				end
			end
			PCRA_T_DECODE: begin
				next_tgt_cnt = tgt_cnt + 3'h1;
				if (positive_hit) begin
					next_tgt_state = PCRA_T_CLAIM;
				end else if (!devsel_n_in) begin
					next_tgt_state = PCRA_T_DONE;
				end else if (subtractive_en && tgt_cnt == SUB_CLAIM_WAIT) begin
					next_tgt_state = PCRA_T_CLAIM;
				end else if (!subtractive_en && tgt_cnt == SUB_CLAIM_WAIT) begin
					next_tgt_state = PCRA_T_DONE;
				end
			end
			PCRA_T_CLAIM: begin
				next_devsel_n_out = 1'b0;
				next_devsel_oe = 1'b1;
				if (frame_n_in && irdy_n_in) begin
					next_tgt_state = PCRA_T_IDLE;
				end
			end
			PCRA_T_DONE: begin
				if (bus_idle) begin
					next_tgt_state = PCRA_T_IDLE;
				end
			end
			default: next_tgt_state = PCRA_T_IDLE;
		endcase
	end

	// parity one cycle after the driven address/data; a foreign data phase is
	// checked a cycle after it completes, when its driver shows the parity
	always_comb begin
		next_par_pend = !ad_oe && !irdy_n_in && !trdy_n_in;
		next_par_src = {ad_in, cbe_n_in};
		next_par_oe = ad_oe;
		next_par_out = pcra_parity(ad_out, cbe_n_out);
		next_parity_error = par_pend
			&& (par_in != pcra_parity(par_src[35:4], par_src[3:0]));
	end

	// nmi from system error when enabled, or from channel check
	always_comb begin
		next_nmi = (nmi_on_serr && !serr_n) || !chan_check_n;
	end

	// clock run: drive low unless stop wanted while the bus and the initiator are idle
	always_comb begin
		next_clk_run_oe = 1'b1;
		next_clk_stop_ok = 1'b0;
		if (clk_stop_req && bus_idle && mst_state == PCRA_IDLE) begin
			next_clk_run_oe = 1'b0;
			// another agent still pulling low keeps the clock alive
			next_clk_stop_ok = !bus_clock_run_oe && bus_clock_run_n_in;
		end
	end

	// extra pairs: simple round robin; plain i/o when not enabled
	always_comb begin
		next_ext_grants = 4'hF;
		next_rr = rr;
		next_gpi = {ext_lo_request_2_n, ext_lo_request_1_n,
			ext_hi_request_2_n, ext_hi_request_1_n};
		if (arbiter_pin_config[CFG_HI_PAIRS_BIT]) begin
			if (!ext_hi_request_1_n && (rr[0] || ext_hi_request_2_n)) begin
				next_ext_grants[0] = 1'b0;
				next_rr[0] = 1'b0;
			end else if (!ext_hi_request_2_n) begin
				next_ext_grants[1] = 1'b0;
				next_rr[0] = 1'b1;
			end
		end else begin
			next_ext_grants[1:0] = gpo_value[1:0];
		end
		if (arbiter_pin_config[CFG_LO_PAIRS_BIT]) begin
			if (!ext_lo_request_1_n && (rr[1] || ext_lo_request_2_n)) begin
				next_ext_grants[2] = 1'b0;
				next_rr[1] = 1'b0;
			end else if (!ext_lo_request_2_n) begin
				next_ext_grants[3] = 1'b0;
				next_rr[1] = 1'b1;
			end
		end else begin
			next_ext_grants[3:2] = gpo_value[3:2];
		end
	end

	// all state registers; reset leaves clock run driven low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mst_state <= PCRA_IDLE;
			tgt_state <= PCRA_T_IDLE;
			wait_cnt <= 3'h0;
			tgt_cnt <= 3'h0;
			cur_hi <= 1'b0;
			is_write <= 1'b0;
			addr_q <= 32'h0;
			wdata_q <= 32'h0;
			cmd_q <= 4'h0;
			be_q <= 4'hF;
			ad_out <= 32'h0;
			ad_oe <= 1'b0;
			cbe_n_out <= 4'hF;
			cbe_oe <= 1'b0;
			frame_n_out <= 1'b1;
			frame_oe <= 1'b0;
			irdy_n_out <= 1'b1;
			irdy_oe <= 1'b0;
			devsel_n_out <= 1'b1;
			devsel_oe <= 1'b0;
			par_pend <= 1'b0;
			par_src <= 36'h0;
			par_out <= 1'b0;
			par_oe <= 1'b0;
			parity_error <= 1'b0;
			nmi <= 1'b0;
			bus_clock_run_oe <= 1'b1;
			clk_stop_ok <= 1'b0;
			hi_prio_bus_request_n <= 1'b1;
			norm_prio_bus_request_n <= 1'b1;
			mst_done <= 1'b0;
			mst_abort <= 1'b0;
			mst_rdata <= 32'h0;
			tgt_cfg_hit <= 1'b0;
			rr <= 2'h0;
			{ext_lo_grant_2_n, ext_lo_grant_1_n, ext_hi_grant_2_n, ext_hi_grant_1_n} <= 4'hF;
			gpi_value <= 4'hF;
		end else begin
			mst_state <= next_mst_state;
			tgt_state <= next_tgt_state;
			wait_cnt <= next_wait_cnt;
			tgt_cnt <= next_tgt_cnt;
			cur_hi <= next_cur_hi;
			is_write <= next_is_write;
			addr_q <= next_addr_q;
			wdata_q <= next_wdata_q;
			cmd_q <= next_cmd_q;
			be_q <= next_be_q;
			ad_out <= next_ad_out;
			ad_oe <= next_ad_oe;
			cbe_n_out <= next_cbe_n_out;
			cbe_oe <= next_cbe_oe;
			frame_n_out <= next_frame_n_out;
			frame_oe <= next_frame_oe;
			irdy_n_out <= next_irdy_n_out;
			irdy_oe <= next_irdy_oe;
			devsel_n_out <= next_devsel_n_out;
			devsel_oe <= next_devsel_oe;
			par_pend <= next_par_pend;
			par_src <= next_par_src;
			par_out <= next_par_out;
			par_oe <= next_par_oe;
			parity_error <= next_parity_error;
			nmi <= next_nmi;
			bus_clock_run_oe <= next_clk_run_oe;
			clk_stop_ok <= next_clk_stop_ok;
			hi_prio_bus_request_n <= next_hi_req_n;
			norm_prio_bus_request_n <= next_norm_req_n;
			mst_done <= next_mst_done;
			mst_abort <= next_mst_abort;
			mst_rdata <= next_mst_rdata;
			tgt_cfg_hit <= next_tgt_cfg_hit;
			rr <= next_rr;
			{ext_lo_grant_2_n, ext_lo_grant_1_n, ext_hi_grant_2_n, ext_hi_grant_1_n} <= next_ext_grants;
			gpi_value <= next_gpi;
		end
	end

	assign bus_clock_run_n_out = 1'b0;
	assign mst_busy = mst_state != PCRA_IDLE;

	a_frame_addr: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(frame_n_out) |-> ad_oe && ad_out == addr_q && cbe_n_out == cmd_q)
		else $error("address or command missing at frame");
	a_frame_last: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(frame_n_out) |=> frame_n_out && !irdy_n_out)
		else $error("frame not dropped for last phase");
	a_irdy_ready: assert property (@(posedge clk) disable iff (!rst_n)
		!irdy_n_out |-> irdy_oe && (mst_state == PCRA_DATA))
		else $error("initiator ready outside data phase");
	a_stop_ends: assert property (@(posedge clk) disable iff (!rst_n)
		mst_state == PCRA_DATA && !stop_n_in && trdy_n_in |=> mst_abort && mst_state == PCRA_TURN)
		else $error("stop did not end transaction");
	a_par_value: assert property (@(posedge clk) disable iff (!rst_n)
		ad_oe |=> par_oe && par_out == ^{$past(ad_out), $past(cbe_n_out)})
		else $error("parity wrong");
	a_nmi_serr: assert property (@(posedge clk) disable iff (!rst_n)
		nmi_on_serr && !serr_n |=> nmi)
		else $error("no nmi on system error");
	a_nmi_chk: assert property (@(posedge clk) disable iff (!rst_n)
		!chan_check_n |=> nmi)
		else $error("no nmi on channel check");
	a_clkrun_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!clk_stop_req |=> bus_clock_run_oe)
		else $error("clock run released while clock needed");
	a_start_grant: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(frame_n_out) |-> $past(granted) && $past(bus_idle))
		else $error("started without grant");
	a_ext_hi_off: assert property (@(posedge clk) disable iff (!rst_n)
		!arbiter_pin_config[CFG_HI_PAIRS_BIT] |=>
		{ext_hi_grant_2_n, ext_hi_grant_1_n} == $past(gpo_value[1:0]))
		else $error("high pair active while disabled");
endmodule : pcra_agent

/* File: rtl/pcra_pkg.sv */
package pcra_pkg;
	// bus commands of interest
	localparam logic [3:0] CMD_CFG_READ = 4'hA;
	localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	// configuration select sits on address line 28
	localparam int IDSEL_BIT = 28;
	// arbiter pin configuration field positions
	localparam int CFG_HI_PAIRS_BIT = 3;
	localparam int CFG_LO_PAIRS_BIT = 2;
	// cycles to wait for a positive claim before claiming subtractively
	localparam logic [2:0] SUB_CLAIM_WAIT = 3'h3;
	// cycles to wait for a target claim before master abort
	localparam logic [2:0] MASTER_ABORT_WAIT = 3'h5;
	localparam logic [7:0] ARB_CFG_RESET = 8'h00;
	typedef enum logic [2:0] {
		PCRA_IDLE = 3'b000,
		PCRA_REQ = 3'b001,
		PCRA_ADDR = 3'b010,
		PCRA_DATA = 3'b011,
		PCRA_TURN = 3'b100
	} pcra_mst_t;
	typedef enum logic [1:0] {
		PCRA_T_IDLE = 2'b00,
		PCRA_T_DECODE = 2'b01,
		PCRA_T_CLAIM = 2'b10,
		PCRA_T_DONE = 2'b11
	} pcra_tgt_t;
endpackage : pcra_pkg

/* File: sim/pcra_far_side.sv */
`timescale 1ns/1ps
module pcra_far_side (
	input wire logic clk, // bus clock
	input wire logic rst_n, // reset, active low
	input wire logic hi_req_n, // high priority request
	input wire logic norm_req_n, // normal priority request
	input wire logic frame_n, // bus frame
	input wire logic irdy_n, // bus initiator ready
	input wire logic [31:0] ad, // bus address/data
	input wire logic [3:0] cbe_n, // bus command/byte enables
	input wire logic [1:0] mode, // 0 answer, 1 stop, 2 silent
	input wire logic [2:0] lat, // wait before grant and answer
	input wire logic bad_par, // flip driven parity
	output logic hi_gnt_n, // high priority grant
	output logic norm_gnt_n, // normal priority grant
	output logic trdy_n, // target ready, high when released
	output logic stop_n, // stop, high when released
	output logic devsel_n, // device select, high when released
	output logic [31:0] rd_data, // read data
	output logic rd_oe, // read data enable
	output logic par, // parity of data it drove
	output logic par_oe, // parity enable
	output logic [31:0] wr_seen // last write data taken
);
	logic [2:0] gcnt;
	logic [2:0] tcnt;
	logic act;
	logic rd;
	logic frame_q;
	// arbiter: grant after lat cycles of request, withdrawn with the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gcnt <= 3'h0;
			{hi_gnt_n, norm_gnt_n} <= 2'h3;
		end else if (hi_req_n && norm_req_n) begin
			gcnt <= 3'h0;
			{hi_gnt_n, norm_gnt_n} <= 2'h3;
		end else if (gcnt < lat) begin
			gcnt <= gcnt + 3'h1;
		end else begin
			hi_gnt_n <= hi_req_n;
			norm_gnt_n <= hi_req_n ? norm_req_n : 1'b1;
		end
	end
	// target: answers each cycle it sees begin unless mode is 2, slow by lat; parity follows its own data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{act, rd, tcnt, rd_oe, par_oe, par} <= 8'h00;
			{trdy_n, stop_n, devsel_n, frame_q} <= 4'hF;
			rd_data <= 32'h00000000;
			wr_seen <= 32'h00000000;
		end else begin
			frame_q <= frame_n;
			par <= ^{ad, cbe_n} ^ bad_par;
			par_oe <= rd_oe;
			if (frame_q && !frame_n && mode != 2'h2) begin
				act <= 1'b1;
				rd <= !cbe_n[0];
				rd_data <= ~ad;
				tcnt <= 3'h0;
			end else if (act && !irdy_n && !(trdy_n && stop_n)) begin
				if (!trdy_n && !rd) wr_seen <= ad;
				{act, rd_oe} <= 2'h0;
				{trdy_n, stop_n, devsel_n} <= 3'h7;
			end else if (act) begin
				tcnt <= tcnt + 3'h1;
				devsel_n <= 1'b0;
				rd_oe <= rd;
				if (tcnt >= lat) begin
					trdy_n <= mode[0];
					stop_n <= !mode[0];
				end
			end
		end
	end
endmodule : pcra_far_side

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import pcra_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int fails = 0;
	int checked = 0;
	logic [31:0] ad_out, mst_rdata, rd_data, wr_seen, ad_bus;
	logic [3:0] cbe_n_out, gpi_value, cbe_bus;
	logic ad_oe, cbe_oe, frame_n_out, frame_oe, irdy_n_out, irdy_oe, devsel_n_out, devsel_oe;
	logic par_out, par_oe, parity_error, nmi, bus_clock_run_n_out, bus_clock_run_oe, clk_stop_ok;
	logic hi_prio_bus_request_n, norm_prio_bus_request_n, mst_busy, mst_done, mst_abort;
	logic tgt_cfg_hit, ext_hi_grant_1_n, ext_hi_grant_2_n, ext_lo_grant_1_n, ext_lo_grant_2_n;
	logic hi_prio_bus_grant_n, norm_prio_bus_grant_n, fs_trdy_n, fs_stop_n, fs_devsel_n;
	logic rd_oe, fs_par, fs_par_oe, frame_bus, irdy_bus, devsel_bus, par_bus, ckrun_bus;
	logic serr_n = 1'b1, chan_check_n = 1'b1, nmi_on_serr = 1'b0, clk_stop_req = 1'b0;
	logic mst_start = 1'b0, mst_hi_prio = 1'b0, positive_hit = 1'b0, subtractive_en = 1'b0;
	logic [3:0] mst_cmd = 4'h0, mst_be_n = 4'h0, gpo_value = 4'h0, ext_req_n = 4'hF, tb_cbe = 4'h0;
	logic [31:0] mst_addr = 32'h0, mst_wdata = 32'h0, tb_ad = 32'h0, idle_pat = 32'h0;
	logic [7:0] arbiter_pin_config = 8'h00;
	logic tb_init = 1'b0, tb_frame_n = 1'b1, tb_irdy_n = 1'b1, tb_devsel_n = 1'b1;
	logic tb_ckrun_n = 1'b1, bad_par = 1'b0;
	logic [1:0] fs_mode = 2'h0;
	logic [2:0] fs_lat = 3'h0;
	always #12.5 clk = ~clk; // timing counts cycles except the 2 ns input offset and the watchdog, so the period is not critical
	// released control lines float high; released ad/cbe show a changing pattern
	always @(posedge clk) idle_pat <= idle_pat + 32'h9E3779B9;
	assign ad_bus = ad_oe ? ad_out : rd_oe ? rd_data : tb_init ? tb_ad : idle_pat;
	assign cbe_bus = cbe_oe ? cbe_n_out : tb_init ? tb_cbe : idle_pat[7:4];
	assign frame_bus = (frame_n_out | !frame_oe) & tb_frame_n;
	assign irdy_bus = (irdy_n_out | !irdy_oe) & tb_irdy_n;
	assign devsel_bus = (devsel_n_out | !devsel_oe) & fs_devsel_n & tb_devsel_n;
	assign par_bus = par_oe ? par_out : fs_par_oe ? fs_par : idle_pat[9];
	assign ckrun_bus = (bus_clock_run_n_out | !bus_clock_run_oe) & tb_ckrun_n;
	pcra_agent DUT (
		.clk, .rst_n, .ad_in(ad_bus), .ad_out, .ad_oe, .cbe_n_in(cbe_bus), .cbe_n_out, .cbe_oe,
		.frame_n_in(frame_bus), .frame_n_out, .frame_oe, .irdy_n_in(irdy_bus), .irdy_n_out,
		.irdy_oe, .trdy_n_in(fs_trdy_n), .stop_n_in(fs_stop_n), .devsel_n_in(devsel_bus),
		.devsel_n_out, .devsel_oe, .par_in(par_bus), .par_out, .par_oe, .parity_error, .serr_n,
		.chan_check_n, .nmi_on_serr, .nmi, .bus_clock_run_n_in(ckrun_bus), .bus_clock_run_n_out,
		.bus_clock_run_oe, .clk_stop_req, .clk_stop_ok, .hi_prio_bus_request_n,
		.hi_prio_bus_grant_n, .norm_prio_bus_request_n, .norm_prio_bus_grant_n, .mst_start,
		.mst_hi_prio, .mst_cmd, .mst_addr, .mst_wdata, .mst_be_n, .mst_busy, .mst_done,
		.mst_abort, .mst_rdata, .positive_hit, .subtractive_en, .tgt_cfg_hit, .arbiter_pin_config,
		.ext_hi_request_1_n(ext_req_n[0]), .ext_hi_request_2_n(ext_req_n[1]),
		.ext_lo_request_1_n(ext_req_n[2]), .ext_lo_request_2_n(ext_req_n[3]), .ext_hi_grant_1_n,
		.ext_hi_grant_2_n, .ext_lo_grant_1_n, .ext_lo_grant_2_n, .gpo_value, .gpi_value
	);
	pcra_far_side FS (
		.clk, .rst_n, .hi_req_n(hi_prio_bus_request_n), .norm_req_n(norm_prio_bus_request_n),
		.frame_n(frame_bus), .irdy_n(irdy_bus), .ad(ad_bus), .cbe_n(cbe_bus), .mode(fs_mode),
		.lat(fs_lat), .bad_par, .hi_gnt_n(hi_prio_bus_grant_n),
		.norm_gnt_n(norm_prio_bus_grant_n), .trdy_n(fs_trdy_n), .stop_n(fs_stop_n),
		.devsel_n(fs_devsel_n), .rd_data, .rd_oe, .par(fs_par), .par_oe(fs_par_oe), .wr_seen
	);
	// shared compare and clock stepping; inputs always change 2 ns after the edge
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	// one transfer as initiator; md 0 answer, 1 stop, 2 no claim; a start while busy is ignored
	task automatic t_master(input logic [3:0] cmd, input logic hi, input logic [1:0] md,
			input logic [2:0] lt, input logic bp);
		logic perr;
		perr = 1'b0;
		{fs_mode, fs_lat, bad_par} = {md, lt, bp};
		{mst_cmd, mst_hi_prio, mst_be_n, mst_start} = {cmd, hi, ~cmd, 1'b1};
		mst_addr = 32'h20000000 + {bp, md, lt, cmd, 4'h0};
		mst_wdata = ~mst_addr;
		step(1);
		mst_start = 1'b0;
		for (int i = 0; i < 6 && hi_prio_bus_request_n && norm_prio_bus_request_n; i++) step(1);
		chk({hi_prio_bus_request_n, norm_prio_bus_request_n}, {!hi, hi});
		for (int i = 0; i < 12 && !(frame_oe && !frame_n_out); i++) step(1);
		chk({frame_oe, frame_n_out, hi ? hi_prio_bus_grant_n : norm_prio_bus_grant_n, ad_oe,
			cbe_oe}, 5'h13);
		chk(ad_out, mst_addr);
		chk(cbe_n_out, cmd);
		step(1);
		chk({par_oe, par_out}, {1'b1, ^{mst_addr, cmd}});
		chk({frame_n_out, irdy_oe, irdy_n_out, ad_oe, cbe_n_out}, {3'h6, cmd[0], ~cmd});
		if (cmd[0]) chk(ad_out, mst_wdata);
		mst_start = 1'b1;
		step(1);
		mst_start = 1'b0;
		for (int i = 0; i < 14 && !mst_done; i++) begin
			perr |= parity_error;
			step(1);
		end
		chk({mst_done, mst_abort}, {1'b1, md != 2'h0});
		if (md == 2'h0) chk(cmd[0] ? wr_seen : mst_rdata, ~mst_addr);
		for (int i = 0; i < 3; i++) begin
			step(1);
			perr |= parity_error;
		end
		chk(perr, bp);
		chk({hi_prio_bus_request_n, norm_prio_bus_request_n, mst_busy}, 3'h6);
		$display("master test cmd %h done", cmd);
	endtask : t_master
	// the bench starts a cycle; how = {other claims, positive hit, subtractive enable}
	task automatic t_target(input logic [3:0] cmd, input logic [31:0] a, input logic [2:0] how,
			output int cyc, output logic cfg);
		cyc = -1;
		cfg = 1'b0;
		{positive_hit, subtractive_en} = how[1:0];
		{tb_init, tb_frame_n, tb_ad, tb_cbe} = {2'h2, a, cmd};
		step(1);
		{tb_frame_n, tb_irdy_n, tb_ad, tb_devsel_n} = {2'h2, ~a, !how[2]};
		for (int i = 0; i < 8; i++) begin
			cfg |= tgt_cfg_hit;
			if (cyc < 0 && devsel_oe && !devsel_n_out) cyc = i;
			step(1);
		end
		{tb_init, tb_irdy_n, tb_devsel_n} = 3'h3;
		step(3);
		chk(devsel_oe && !devsel_n_out, 1'b0);
		$display("target test cmd %h done", cmd);
	endtask : t_target
	// every mix of system error, channel check and enable
	task automatic t_nmi;
		for (int i = 0; i < 8; i++) begin
			{serr_n, chan_check_n, nmi_on_serr} = i[2:0];
			step(1);
			chk(nmi, (!serr_n && nmi_on_serr) || !chan_check_n);
		end
		{serr_n, chan_check_n} = 2'h3;
		$display("nmi test done");
	endtask : t_nmi
	// clock stop is granted only while no other agent holds the line low
	task automatic t_clkrun;
		clk_stop_req = 1'b1;
		for (int i = 0; i < 8 && !clk_stop_ok; i++) step(1);
		chk({clk_stop_ok, bus_clock_run_oe, ckrun_bus}, 3'h5);
		tb_ckrun_n = 1'b0;
		for (int i = 0; i < 8 && clk_stop_ok; i++) step(1);
		chk(clk_stop_ok, 1'b0);
		{tb_ckrun_n, clk_stop_req} = 2'h2;
		step(3);
		chk({clk_stop_ok, bus_clock_run_oe, ckrun_bus}, 3'h2);
		$display("clock run test done");
	endtask : t_clkrun
	// extra pairs: disabled groups show gpo_value, enabled ones grant only the requester
	task automatic t_pairs;
		logic [3:0] low;
		for (int c = 0; c < 3; c++) begin
			{arbiter_pin_config, gpo_value, ext_req_n} = {4'h0, c[1:0], 2'h0, 4'h5, 4'hA};
			low = 4'h0;
			for (int i = 0; i < 8; i++) begin
				step(1);
				if (i > 0) low |= ~{ext_lo_grant_2_n, ext_lo_grant_1_n, ext_hi_grant_2_n,
					ext_hi_grant_1_n};
			end
			chk(low[1:0], c[1] ? 2'h1 : 2'h2);
			chk(low[3:2], c[0] ? 2'h1 : 2'h2);
		end
		chk(gpi_value, 4'hA);
		$display("request pairs test done");
	endtask : t_pairs
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#60000;
		fails++;
		final_report();
	end
	// main sequence
	initial begin
		int c1;
		int c2;
		logic f;
		step(12);
		chk({frame_oe, ad_oe, devsel_oe, bus_clock_run_oe, bus_clock_run_n_out,
			hi_prio_bus_request_n, norm_prio_bus_request_n, nmi, mst_done}, 9'h02C);
		rst_n = 1'b1;
		step(1);
		t_master(CMD_MEM_WRITE, 1'b0, 2'h0, 3'h0, 1'b0);
		t_master(CMD_MEM_READ, 1'b1, 2'h0, 3'h2, 1'b0);
		t_master(CMD_MEM_READ, 1'b0, 2'h0, 3'h0, 1'b1);
		t_master(CMD_CFG_WRITE, 1'b1, 2'h1, 3'h1, 1'b0);
		t_master(CMD_CFG_READ, 1'b0, 2'h2, 3'h0, 1'b0);
		fs_mode = 2'h2;
		t_target(CMD_CFG_WRITE, 32'h10000000, 3'h0, c1, f);
		chk({c1 >= 0, f}, 2'h3);
		t_target(CMD_CFG_READ, 32'hEFFFFFFF, 3'h0, c1, f);
		chk({c1 >= 0, f}, 2'h0);
		t_target(CMD_MEM_READ, 32'h00001000, 3'h2, c1, f);
		t_target(CMD_MEM_WRITE, 32'h00002000, 3'h1, c2, f);
		chk({c1 >= 0, c2 > c1}, 2'h3);
		t_target(CMD_MEM_READ, 32'h00003000, 3'h5, c2, f);
		chk(c2 >= 0, 1'b0);
		t_nmi();
		t_clkrun();
		t_pairs();
		final_report();
	end
endmodule : tb_top
